/* carray_map.svh */
// Register offsets, field positions, reset values and divider counts
`ifndef CARRAY_MAP_SVH
`define CARRAY_MAP_SVH

// Register addresses on the special-function register bus
`define CN_ADDR       8'hd8
`define MD_ADDR       8'hd9
`define CNT_LO_ADDR   8'hf9
`define CNT_HI_ADDR   8'hfa
`define MODE_BASE     8'hda
`define CMP_LO_BASE   8'he0
`define CMP_HI_BASE   8'he8
`define MOD_COUNT     8'h06
`define WD_SLOT       3'd5

// Control/flag register fields
`define CN_OVF        7
`define CN_RUN        6
`define CN_WD_FLAG    5

// Array mode register fields
`define MD_IDLE       7
`define MD_WDEN       6
`define MD_WATCHDOG_LOCK      5
`define MD_SEL_HI     3
`define MD_SEL_LO     1
`define MD_IRQEN      0

// Module mode register fields
`define MODE_PWM16    7
`define MODE_ECOM     6
`define MODE_MAT      3
`define MODE_PWM      1
`define MODE_ECCF     0

// Reset values
`define WD_EN_RESET   1'b1
`define CN_RESET      8'h00

// Prescaler terminal counts for the divided system clock
`define DIV12_LAST    4'd11
`define DIV4_LAST     4'd3
`endif

/* carray_pkg.sv */
// Types and helpers shared by the counter array modules
`default_nettype none
package carray_pkg;

	// Counter clock source codes
	typedef enum logic [2:0] {
		SRC_SYS_DIV12 = 3'h0,
		SRC_SYS_DIV4  = 3'h1,
		SRC_TIMER0    = 3'h2,
		SRC_EXT_PIN   = 3'h3,
		SRC_SYS       = 3'h4,
		SRC_EXT_OSC   = 3'h5,
		SRC_RTC       = 3'h6
	} clk_src_t;

	// Registers held directly by the top-level block, not by its compare modules or watchdog
	typedef struct packed {
		logic            ovf_flag;
		logic            run_ctl;
		logic [5:0]      mod_flag;
		logic            idle_susp;
		logic            wd_enable;
		logic            wd_lock;
		logic [2:0]      clk_sel;
		logic            ovf_irq_en;
		logic [15:0]     cnt;
		logic [5:0][7:0] mode;
		logic [5:0][7:0] cmp_lo;
		logic [5:0][7:0] cmp_hi;
		logic [3:0]      pre;
		logic [2:0]      pin_sync;
		logic            pin_level;
		logic [7:0]      rdata;
		logic            irq;
	} core_state_t;

	typedef struct packed {
		logic level;
	} pwm_state_t;

	typedef struct packed {
		logic fire;
	} wd_state_t;

	// Value the counter takes on its next step
	function automatic logic [15:0] cnt_next(input logic [15:0] c);
		cnt_next = c + 16'h0001;
	endfunction : cnt_next

	// Slot decode: bit 3 valid, bits 2:0 module index
	function automatic logic [3:0] mod_slot(input logic [7:0] addr,
		input logic [7:0] base);
		logic [7:0] d;
		d = addr - base;
		mod_slot = (d < 8'h06) ? {1'b1, d[2:0]} : 4'h0;
	endfunction : mod_slot

endpackage : carray_pkg
`default_nettype wire

/* carray_cnt_if.sv */
// Shared counter view handed from the array core to its modules
`timescale 1ns/100ps
`default_nettype none
interface carray_cnt_if;
	logic [15:0] count;
	logic        step;
	logic        wd_active;

	modport src (output count, output step, output wd_active);
	modport snk (input count, input step, input wd_active);
endinterface : carray_cnt_if
`default_nettype wire

/* carray_pwm16.sv */
// One compare module: 16-bit pulse-width output and match flag event
`timescale 1ns/100ps
`default_nettype none
`include "carray_map.svh"
module carray_pwm16
(
	input  wire logic          sys_clk,
	input  wire logic          rst,
	carray_cnt_if.snk          link,
	input  wire logic [7:0]    mode,
	input  wire logic [15:0]   cmp,
	input  wire logic          force_timer,
	output logic               pin_r,
	output logic               flag_evt
);
	import carray_pkg::*;

	pwm_state_t st_r;
	pwm_state_t st_nxt;
	logic       hit;
	logic       wrap;
	logic       ecom;
	logic       mat;
	logic       pwm_on;

	// Watchdog slot is forced to plain compare, no waveform
	always_comb
	begin
		ecom = mode[`MODE_ECOM] | force_timer;
		mat = mode[`MODE_MAT] | force_timer;
		pwm_on = ecom & mode[`MODE_PWM] & mode[`MODE_PWM16]
			& !force_timer;
		hit = link.step && (cnt_next(link.count) == cmp);
		wrap = link.step && (cnt_next(link.count) == 16'h0000);
		flag_evt = hit && ecom && mat;
		st_nxt = st_r;
		if (!pwm_on)
			st_nxt.level = 1'b0;
		else if (hit)
			st_nxt.level = 1'b1;
		else if (wrap)
			st_nxt.level = 1'b0;
	end

	// Match beats wrap, so a zero compare stays high
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign pin_r = st_r.level;

	a_pwm_rise: assert property (@(posedge sys_clk) disable iff (rst)
		(pwm_on && hit) |=> pin_r)
		else $error("output did not rise on match");

	a_pwm_off: assert property (@(posedge sys_clk) disable iff (rst)
		!ecom |=> !pin_r)
		else $error("output high with compare disabled");

	a_pwm_fall: assert property (@(posedge sys_clk) disable iff (rst)
		(pwm_on && wrap && cmp != 16'h0000) ##1 pwm_on |-> !pin_r)
		else $error("output not low after wrap");

endmodule : carray_pwm16
`default_nettype wire

/* carray_watchdog.sv */
// Watchdog expiry detection on the sixth compare module
`timescale 1ns/100ps
`default_nettype none
`include "carray_map.svh"
module carray_watchdog
(
	input  wire logic          sys_clk,
	input  wire logic          rst,
	carray_cnt_if.snk          link,
	input  wire logic [7:0]    upd_cmp,
	input  wire logic          force_req,
	output logic               reset_r
);
	import carray_pkg::*;

	wd_state_t st_r;
	wd_state_t st_nxt;
	logic      lo_ovf;

	// Expiry: low byte wraps while high byte equals update compare
	always_comb
	begin
		lo_ovf = link.step && (link.count[7:0] == 8'hff);
		st_nxt.fire = link.wd_active
			&& ((lo_ovf && upd_cmp == link.count[15:8])
			|| force_req);
	end

	// One-cycle reset request; the system reset clears us anyway
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign reset_r = st_r.fire;

	a_wd_expire: assert property (@(posedge sys_clk) disable iff (rst)
		(link.wd_active && lo_ovf && upd_cmp == link.count[15:8])
		|=> reset_r)
		else $error("watchdog expiry did not reset");

	a_wd_force: assert property (@(posedge sys_clk) disable iff (rst)
		(link.wd_active && force_req) |=> reset_r)
		else $error("forced watchdog reset missing");

	a_wd_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		!link.wd_active |=> !reset_r)
		else $error("reset while watchdog disabled");

endmodule : carray_watchdog
`default_nettype wire

/* carray_core.sv */
// Counter array core: counter, flags, register bus, compare modules
`timescale 1ns/100ps
`default_nettype none
`include "carray_map.svh"
module carray_core
(
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire logic [7:0]    sfr_addr,
	input  wire logic [7:0]    sfr_wdata,
	input  wire logic          sfr_wr,
	input  wire logic          sfr_rd,
	output logic [7:0]         sfr_rdata,
	input  wire logic          cpu_idle,
	input  wire logic          timer0_ovf,
	input  wire logic          ext_osc_tick,
	input  wire logic          rtc_tick,
	input  wire logic          ext_clk_pin,
	output logic [5:0]         module_output_pin,
	output logic               array_irq,
	output logic               wdt_reset
);
	import carray_pkg::*;

	core_state_t st_r;
	core_state_t st_nxt;
	logic        wd_on;
	logic        tick;
	logic        step;
	logic        pin_edge;
	logic        force_req;
	logic [3:0]  div_last;
	logic [3:0]  slot;
	logic [5:0]  flag_evt;
	logic [5:0]  pin_w;
	logic [5:0]  flag_irq_en;
	logic        wd_reset_w;

	carray_cnt_if cnt_link ();

	// Lock alone keeps the watchdog alive
	assign wd_on = st_r.wd_enable | st_r.wd_lock;
	assign force_req = sfr_wr && (sfr_addr == `CN_ADDR)
		&& sfr_wdata[`CN_WD_FLAG];

	// Counter view for the compare modules
	assign cnt_link.count = st_r.cnt;
	assign cnt_link.step = step;
	assign cnt_link.wd_active = wd_on;

	// Compare modules; slot five doubles as the watchdog timer
	for (genvar i = 0; i < 6; i++)
	begin : g_mod
		carray_pwm16 u_pwm (
			.sys_clk     (sys_clk),
			.rst         (rst),
			.link        (cnt_link),
			.mode        (st_r.mode[i]),
			.cmp         ({st_r.cmp_hi[i], st_r.cmp_lo[i]}),
			.force_timer ((i == 5) ? wd_on : 1'b0),
			.pin_r       (pin_w[i]),
			.flag_evt    (flag_evt[i])
		);
		assign flag_irq_en[i] = st_r.mode[i][`MODE_ECCF];
	end

	carray_watchdog u_wd (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.link      (cnt_link),
		.upd_cmp   (st_r.cmp_hi[5]),
		.force_req (force_req),
		.reset_r   (wd_reset_w)
	);

	// Counter clock, stepping, register writes, flags and readback
	always_comb
	begin
		st_nxt = st_r;
		slot = 4'h0;

		// External clock pin: three stages, count once stages agree
		st_nxt.pin_sync = {st_r.pin_sync[1:0], ext_clk_pin};
		if (st_r.pin_sync[1] == st_r.pin_sync[2])
			st_nxt.pin_level = st_r.pin_sync[2];
		pin_edge = (st_r.pin_sync[1] == st_r.pin_sync[2])
			&& st_r.pin_sync[2] && !st_r.pin_level;

		// Prescaler serves both divided system clock choices
		div_last = (st_r.clk_sel == SRC_SYS_DIV4) ? `DIV4_LAST
			: `DIV12_LAST;
		st_nxt.pre = (st_r.pre >= div_last) ? 4'h0 : st_r.pre + 4'h1;

		case (st_r.clk_sel)
			SRC_SYS_DIV12: tick = (st_r.pre >= div_last);
			SRC_SYS_DIV4:  tick = (st_r.pre >= div_last);
			SRC_TIMER0:    tick = timer0_ovf;
			SRC_EXT_PIN:   tick = pin_edge;
			SRC_SYS:       tick = 1'b1;
			SRC_EXT_OSC:   tick = ext_osc_tick;
			SRC_RTC:       tick = rtc_tick;
			default:       tick = 1'b0;
		endcase

		// Watchdog overrides the run bit; idle can still pause it
		step = tick && (st_r.run_ctl || wd_on)
			&& !(st_r.idle_susp && cpu_idle);
		if (step)
			st_nxt.cnt = cnt_next(st_r.cnt);

		// Software writes first, so hardware sets below win
		if (sfr_wr)
		begin
			if (sfr_addr == `CN_ADDR)
			begin
				st_nxt.ovf_flag = sfr_wdata[`CN_OVF];
				st_nxt.run_ctl = sfr_wdata[`CN_RUN];
				st_nxt.mod_flag = sfr_wdata[5:0];
			end
			else if (sfr_addr == `MD_ADDR)
			begin
				if (!wd_on)
				begin
					st_nxt.idle_susp = sfr_wdata[`MD_IDLE];
					st_nxt.clk_sel = sfr_wdata[`MD_SEL_HI:`MD_SEL_LO];
				end
				st_nxt.wd_enable = sfr_wdata[`MD_WDEN];
				st_nxt.wd_lock = st_r.wd_lock | sfr_wdata[`MD_WATCHDOG_LOCK];
				st_nxt.ovf_irq_en = sfr_wdata[`MD_IRQEN];
			end
			else if (sfr_addr == `CNT_LO_ADDR)
			begin
				if (!wd_on)
					st_nxt.cnt[7:0] = sfr_wdata;
			end
			else if (sfr_addr == `CNT_HI_ADDR)
			begin
				if (!wd_on)
					st_nxt.cnt[15:8] = sfr_wdata;
			end
			else if (mod_slot(sfr_addr, `MODE_BASE) != 4'h0)
			begin
				slot = mod_slot(sfr_addr, `MODE_BASE);
				if (!(wd_on && slot[2:0] == `WD_SLOT))
					st_nxt.mode[slot[2:0]] = sfr_wdata;
			end
			else if (mod_slot(sfr_addr, `CMP_LO_BASE) != 4'h0)
			begin
				slot = mod_slot(sfr_addr, `CMP_LO_BASE);
				st_nxt.cmp_lo[slot[2:0]] = sfr_wdata;
				if (!(wd_on && slot[2:0] == `WD_SLOT))
					st_nxt.mode[slot[2:0]][`MODE_ECOM] = 1'b0;
			end
			else if (mod_slot(sfr_addr, `CMP_HI_BASE) != 4'h0)
			begin
				slot = mod_slot(sfr_addr, `CMP_HI_BASE);
				if (wd_on && slot[2:0] == `WD_SLOT)
					st_nxt.cmp_hi[slot[2:0]] = st_r.cnt[15:8]
						+ st_r.cmp_lo[slot[2:0]];
				else
				begin
					st_nxt.cmp_hi[slot[2:0]] = sfr_wdata;
					st_nxt.mode[slot[2:0]][`MODE_ECOM] = 1'b1;
				end
			end
		end

		// Hardware flag sets, winning over a same-cycle clear
		if (step && st_r.cnt == 16'hffff)
			st_nxt.ovf_flag = 1'b1;
		st_nxt.mod_flag = st_nxt.mod_flag | flag_evt;

		// Array interrupt request from enabled sticky flags
		st_nxt.irq = (st_r.ovf_flag && st_r.ovf_irq_en)
			|| ((st_r.mod_flag & flag_irq_en) != 6'h00);

		// Readback, one cycle after the read strobe
		if (sfr_rd)
		begin
			if (sfr_addr == `CN_ADDR)
				st_nxt.rdata = {st_r.ovf_flag, st_r.run_ctl, st_r.mod_flag};
			else if (sfr_addr == `MD_ADDR)
				st_nxt.rdata = {st_r.idle_susp, st_r.wd_enable, st_r.wd_lock,
					1'b0, st_r.clk_sel, st_r.ovf_irq_en};
			else if (sfr_addr == `CNT_LO_ADDR)
				st_nxt.rdata = st_r.cnt[7:0];
			else if (sfr_addr == `CNT_HI_ADDR)
				st_nxt.rdata = st_r.cnt[15:8];
			else if (mod_slot(sfr_addr, `MODE_BASE) != 4'h0)
				st_nxt.rdata = st_r.mode[sfr_addr[2:0] - 3'h2];
			else if (mod_slot(sfr_addr, `CMP_LO_BASE) != 4'h0)
				st_nxt.rdata = st_r.cmp_lo[sfr_addr[2:0]];
			else if (mod_slot(sfr_addr, `CMP_HI_BASE) != 4'h0)
				st_nxt.rdata = st_r.cmp_hi[sfr_addr[2:0]];
			else
				st_nxt.rdata = 8'h00;
		end
	end

	// Reset leaves the watchdog armed at divide by twelve
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= '0;
			st_r.wd_enable <= `WD_EN_RESET;
		end
		else
			st_r <= st_nxt;
	end

	// Outputs straight from flip-flops
	assign sfr_rdata = st_r.rdata;
	assign array_irq = st_r.irq;
	assign module_output_pin = pin_w;
	assign wdt_reset = wd_reset_w;

	a_ovf_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
		(step && st_r.cnt == 16'hffff) |=> st_r.ovf_flag)
		else $error("overflow flag missed a wrap");

	a_cnt_wr_block: assert property (@(posedge sys_clk) disable iff (rst)
		(wd_on && sfr_wr && !step
		&& (sfr_addr == `CNT_LO_ADDR || sfr_addr == `CNT_HI_ADDR))
		|=> $stable(st_r.cnt))
		else $error("counter written while watchdog on");

	a_sel_frozen: assert property (@(posedge sys_clk) disable iff (rst)
		(wd_on && sfr_wr && sfr_addr == `MD_ADDR)
		|=> $stable(st_r.clk_sel) && $stable(st_r.idle_susp))
		else $error("clock select changed under watchdog");

	a_run_readback: assert property (@(posedge sys_clk) disable iff (rst)
		(sfr_rd && sfr_addr == `CN_ADDR && !st_r.run_ctl && wd_on)
		|=> !sfr_rdata[`CN_RUN])
		else $error("run bit read as set");

	a_wd_update: assert property (@(posedge sys_clk) disable iff (rst)
		(wd_on && sfr_wr && sfr_addr == (`CMP_HI_BASE + 8'h05))
		|=> st_r.cmp_hi[5] == 8'($past(st_r.cnt[15:8])
		+ $past(st_r.cmp_lo[5])))
		else $error("watchdog update value wrong");

	a_lock_holds: assert property (@(posedge sys_clk) disable iff (rst)
		st_r.wd_lock |=> st_r.wd_lock && wd_on)
		else $error("locked watchdog became disabled");

	a_ecom_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(sfr_wr && sfr_addr == `CMP_LO_BASE)
		|=> !st_r.mode[0][`MODE_ECOM])
		else $error("low byte write left compare enabled");

	a_idle_pause: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r.idle_susp && cpu_idle) |-> !step)
		else $error("counter stepped in suspended idle");

	a_forced_run: assert property (@(posedge sys_clk) disable iff (rst)
		(wd_on && st_r.clk_sel == SRC_SYS && !cpu_idle)
		|=> st_r.cnt == $past(st_r.cnt) + 16'h0001 ||
		$past(sfr_wr))
		else $error("counter not forced on by watchdog");

	// Further guards on stepping, sticky flags and restricted writes
	a_run_stops: assert property (@(posedge sys_clk) disable iff (rst)
		(!st_r.run_ctl && !wd_on) |-> !step)
		else $error("counter stepped while stopped");

	a_div12_step: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r.clk_sel == SRC_SYS_DIV12 && st_r.pre < `DIV12_LAST)
		|-> !step)
		else $error("divided clock stepped early");

	a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r.ovf_flag && !(sfr_wr && sfr_addr == `CN_ADDR))
		|=> st_r.ovf_flag)
		else $error("overflow flag cleared by itself");

	a_ovf_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(sfr_wr && sfr_addr == `CN_ADDR && !sfr_wdata[`CN_OVF]
		&& !(step && st_r.cnt == 16'hffff)) |=> !st_r.ovf_flag)
		else $error("overflow flag not cleared by write");

	a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		!(sfr_wr && sfr_addr == `CN_ADDR) |=> (st_r.mod_flag
		& $past(st_r.mod_flag)) == $past(st_r.mod_flag))
		else $error("module flag cleared by itself");

	a_ovf_irq: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r.ovf_flag && st_r.ovf_irq_en) |=> array_irq)
		else $error("overflow interrupt not requested");

	a_flag_irq: assert property (@(posedge sys_clk) disable iff (rst)
		((st_r.mod_flag & flag_irq_en) != 6'h00) |=> array_irq)
		else $error("module flag interrupt not requested");

	a_ecom_set: assert property (@(posedge sys_clk) disable iff (rst)
		(sfr_wr && sfr_addr == `CMP_HI_BASE)
		|=> st_r.mode[0][`MODE_ECOM])
		else $error("high byte write left compare disabled");

	a_mode5_lock: assert property (@(posedge sys_clk) disable iff (rst)
		(wd_on && sfr_wr && sfr_addr == (`MODE_BASE + 8'h05))
		|=> $stable(st_r.mode[5]))
		else $error("module five mode written under watchdog");

	a_offset_store: assert property (@(posedge sys_clk) disable iff (rst)
		(sfr_wr && sfr_addr == (`CMP_LO_BASE + 8'h05))
		|=> st_r.cmp_lo[5] == $past(sfr_wdata))
		else $error("watchdog offset not stored");

endmodule : carray_core
`default_nettype wire

/* carray_cpu_model.sv */
// Processor core model driving the special-function register bus
`timescale 1ns/100ps
`default_nettype none
module carray_cpu_model
(
	input  wire logic       sys_clk,
	output logic [7:0]      sfr_addr,
	output logic [7:0]      sfr_wdata,
	output logic            sfr_wr,
	output logic            sfr_rd,
	input  wire logic [7:0] sfr_rdata
);
	// Quiet bus at time zero
	initial
	begin
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	end

	// One-cycle write; idle bus shows inverted values, never stale ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		sfr_wr = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
	endtask : wr

	// One-cycle read; data taken once the registered answer has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge sys_clk);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		@(posedge sys_clk);
		#1;
		q = sfr_rdata;
	endtask : rd

	// Compare value written low byte first, so the enable ends up set
	task automatic wr16(input logic [7:0] lo, input logic [7:0] hi,
		input logic [15:0] v);
		wr(lo, v[7:0]);
		wr(hi, v[15:8]);
	endtask : wr16
endmodule : carray_cpu_model
`default_nettype wire

/* counter_array_watchdog_and_pwm16_test.sv */
// Self-checking bench for the counter array core
`timescale 1ns/100ps
`default_nettype none
module counter_array_watchdog_and_pwm16_test;
	logic       sys_clk;
	logic       rst;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_rdata;
	logic       cpu_idle;
	logic       tick_off;
	logic [5:0] pin;
	logic       wdt_reset;
	logic       irq;
	logic [7:0] q;
	logic [7:0] r;
	int         n;
	int         bad_count;
	int         total_checks;

	carray_core carray_core_i (.sys_clk(sys_clk), .rst(rst),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
		.timer0_ovf(tick_off), .ext_osc_tick(tick_off),
		.rtc_tick(tick_off), .ext_clk_pin(tick_off),
		.module_output_pin(pin), .array_irq(irq), .wdt_reset(wdt_reset));

	carray_cpu_model carray_cpu_model_i (.sys_clk(sys_clk),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));

	// 100 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	// Compare seen against expected
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time,
				seen, exp);
		end
	endtask : chk

	// Read a register and compare
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		carray_cpu_model_i.rd(a, q);
		chk({8'h00, q}, {8'h00, exp});
	endtask : rdchk

	// System reset held for four cycles
	task automatic do_reset();
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		rst = 1'b0;
	endtask : do_reset

	// Cycles until module zero's pin or the watchdog reset is seen at the wanted level, bounded
	task automatic wait_lvl(input int lim, input logic want,
		input logic sel, output int k);
		k = 0;
		while (((sel ? pin[0] : wdt_reset) !== want))
		begin
			@(posedge sys_clk);
			#1;
			k++;
			if (k > lim)
			begin
				bad_count++;
				$display("wrong value at %0t: wait ran out", $time);
				close_out();
			end
		end
	endtask : wait_lvl

	// Main sequence
	initial
	begin
		rst = 1'b1;
		cpu_idle = 1'b0;
		tick_off = 1'b0;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(58760));
		// Untouched watchdog expires after 256 steps of sysclk/12
		do_reset();
		wait_lvl(4000, 1'b1, 1'b0, n);
		chk(16'((n >= 3060) && (n <= 3090)), 16'h1);
		// Reset values, blocked counter write, forced expiry
		do_reset();
		rdchk(8'hd9, 8'h40);
		rdchk(8'hd8, 8'h00);
		carray_cpu_model_i.wr(8'hf9, 8'h55);
		carray_cpu_model_i.rd(8'hf9, q);
		chk(16'(q < 8'h10), 16'h1);
		carray_cpu_model_i.wr(8'hd8, 8'h20);
		wait_lvl(3, 1'b1, 1'b0, n);
		chk(16'(n), 16'h0);
		// Lock keeps the watchdog on after enable is cleared
		do_reset();
		carray_cpu_model_i.wr(8'hd9, 8'h00);
		rdchk(8'hd9, 8'h00);
		carray_cpu_model_i.wr(8'hd9, 8'h20);
		carray_cpu_model_i.wr(8'hd9, 8'h00);
		carray_cpu_model_i.rd(8'hd9, q);
		chk({15'h0, q[5]}, 16'h1);
		carray_cpu_model_i.wr(8'hd8, 8'h20);
		wait_lvl(3, 1'b1, 1'b0, n);
		chk(16'(n), 16'h0);
		// Reconfigure: fast clock, offset two, then restart
		do_reset();
		carray_cpu_model_i.wr(8'hd9, 8'h00);
		carray_cpu_model_i.wr(8'hf9, 8'h00);
		carray_cpu_model_i.wr(8'hfa, 8'h00);
		carray_cpu_model_i.wr(8'he5, 8'h02);
		carray_cpu_model_i.wr(8'hd9, 8'hc8);
		carray_cpu_model_i.wr(8'hd9, 8'h40);
		rdchk(8'hd9, 8'hc8);
		carray_cpu_model_i.wr(8'hed, 8'h77);
		wait_lvl(1000, 1'b1, 1'b0, n);
		// Low byte near seven at the update: 512 + 256 - 7
		chk(16'((n >= 755) && (n <= 768)), 16'h1);
		rdchk(8'hed, 8'h02);
		// Suspended idle freezes the running counter
		cpu_idle = 1'b1;
		carray_cpu_model_i.rd(8'hf9, r);
		carray_cpu_model_i.rd(8'hf9, q);
		chk({8'h00, q}, {8'h00, r});
		cpu_idle = 1'b0;
		// 16-bit pulse width on module zero, corner then random
		for (int i = 0; i < 3; i++)
		begin
			r = (i == 0) ? 8'hff : 8'($urandom);
			do_reset();
			carray_cpu_model_i.wr(8'hd9, 8'h00);
			carray_cpu_model_i.wr(8'hd9, 8'h08);
			carray_cpu_model_i.wr(8'hf9, 8'h00);
			carray_cpu_model_i.wr(8'hfa, 8'hfe);
			carray_cpu_model_i.wr(8'hda, 8'hcb);
			carray_cpu_model_i.wr16(8'he0, 8'he8, {8'hff, r});
			rdchk(8'hda, 8'hcb);
			chk({15'h0, pin[0]}, 16'h0);
			carray_cpu_model_i.wr(8'hd8, 8'h40);
			wait_lvl(700, 1'b1, 1'b1, n);
			wait_lvl(300, 1'b0, 1'b1, n);
			chk(16'(n), 16'(256 - int'(r)));
			chk({15'h0, irq}, 16'h1);
			rdchk(8'hd8, 8'hc1);
			carray_cpu_model_i.wr(8'hd8, 8'h40);
			rdchk(8'hd8, 8'h40);
			chk({15'h0, irq}, 16'h0);
			carray_cpu_model_i.wr(8'he0, r);
			rdchk(8'hda, 8'h8b);
		end
		close_out();
	end
endmodule : counter_array_watchdog_and_pwm16_test
`default_nettype wire
